//--- rtl/dpmc_top.sv
// reference mode control: monitors, mode state machine, holdover store, limiter, APB registers
// Function
// - separate out-of-range flag per reference, 17 ppm
// - window measured against master clock centre
// - both monitors concurrent, refreshed every 1.0-1.5 s
// - dead 8k/19.44M input gives periodic short pulse
// - active reference dead: automatic holdover, flag it; code does this only while the mode pins are 00
// - holdover value captured only normal and locked
// - at most 5 ns phase move per frame
// - total shift from a change at most 200 ns
// - phase slope limited to 5 ns per frame
// - capture range 230 ppm about master clock
// - hold-in range equals capture range
// - normal, choice low: transitions to normal-primary
// - normal, choice high: transitions to normal-secondary
// - holdover mode: only legal holdover transitions
// - freerun selected: always freerun, master clock only
// - fast lock request speeds loop acquisition
// - mode pins 00 normal 01 holdover 10 freerun
// - store frequency every 30 ms, two slots
// - return without corrector realigns phase
`timescale 1ns/1ps
`default_nettype none
`include "dpmc_params.svh"
module dpmc_top
   import dpmc_pkg::*;
#(
   parameter int unsigned GATE_CYCLES = `DPMC_GATE_CYC, // monitor gate
   parameter int unsigned STORE_CYCLES = `DPMC_STORE_CYC, // holdover store period
   parameter int unsigned LOS_CYCLES = `DPMC_LOS_CYC // activity timeout
) (
   input wire logic CLK, // master clock, 25 MHz
   input wire logic RESET, // synchronous, active high
   input wire logic PRIMARY_REFERENCE, // primary reference pin
   input wire logic SECONDARY_REFERENCE, // secondary reference pin
   input wire logic MODE_SELECT_HIGH_BIT, // mode pin, high bit
   input wire logic MODE_SELECT_LOW_BIT, // mode pin, low bit
   input wire logic REFERENCE_CHOICE, // 0 primary, 1 secondary
   input wire logic PHASE_CORRECTION_CONTROL, // corrector on holdover-primary return
   input wire logic FAST_LOCK_REQUEST, // fast acquisition pin
   input wire logic signed [15:0] LOOP_FREQ, // loop frequency word, 0.01 ppm
   input wire logic LOOP_LOCKED, // loop reports lock
   input wire logic signed [9:0] PHASE_ERR_NS, // input to output phase, ns
   input wire logic PSEL, // APB select
   input wire logic PENABLE, // APB enable
   input wire logic PWRITE, // APB direction
   input wire logic [7:0] PADDR, // APB byte address
   input wire logic [31:0] PWDATA, // APB write data
   output logic [31:0] PRDATA, // APB read data
   output logic PREADY, // APB ready
   output logic PSLVERR, // APB error
   output logic PRIMARY_OUT_OF_RANGE, // primary off nominal
   output logic SECONDARY_OUT_OF_RANGE, // secondary off nominal
   output logic HOLDOVER_IND, // in a holdover state
   output logic TIE_ACTIVE, // corrector holds phase offset
   output logic FAST_LOCK, // loop in fast acquisition
   output logic signed [15:0] FREQ_WORD, // frequency to oscillator
   output logic signed [9:0] PHASE_ADJ_NS, // applied phase adjustment
   output logic [2:0] STATE_CODE // present control state
);
   logic [6:0] s1_r; // pin synchroniser, first stage
   logic [6:0] s2_r; // pin synchroniser, second stage
   logic [1:0] mode_w; // decoded mode pins
   logic reference_choice_w; // synced reference choice
   logic pcc_w; // synced phase correction control
   dpmc_state_t state_r; // control state
   dpmc_state_t state_nxt; // its next value
   logic tie_nxt; // move uses the corrector
   logic realign_nxt; // move realigns phase
   logic tie_r; // corrector engaged
   logic [1:0] fs_r; // reference frequency select
   logic [31:0] gate_r; // monitor gate timer
   logic gate_w; // gate end
   logic [31:0] nom_w; // expected edges
   logic [31:0] tol_w; // allowed deviation
   logic pen_w; // dead input pulse mode
   logic pri_oor_w; // primary monitor flag
   logic sec_oor_w; // secondary monitor flag
   logic pri_act_w; // primary toggling
   logic sec_act_w; // secondary toggling
   logic [31:0] st_r; // store timer
   logic wr_idx_r; // slot written next
   logic signed [15:0] slot_r [2]; // holdover store
   logic signed [15:0] hold_r; // frequency used in holdover
   logic store_ok_w; // normal and locked
   logic hold_w; // next state is a holdover one
   logic fast_r; // fast lock level
   logic rd_hit_w; // address mapped
   logic [31:0] rd_w; // read mux

   // clamp to the common capture and hold-in range
   function automatic logic signed [15:0] clampf(input logic signed [15:0] f);
      if (f > `DPMC_CAPT_LIM) begin
         return `DPMC_CAPT_LIM;
      end else if (f < -`DPMC_CAPT_LIM) begin
         return -`DPMC_CAPT_LIM;
      end
      return f;
   endfunction

   // expected edges in one gate for the chosen reference
   function automatic logic [31:0] nom_count(input logic [1:0] fs);
      logic [63:0] hz;
      hz = 64'(`DPMC_HZ_8K);
      case (dpmc_fs_t'(fs))
         FS_1544: hz = 64'(`DPMC_HZ_1544);
         FS_2048: hz = 64'(`DPMC_HZ_2048);
         FS_19440: hz = 64'(`DPMC_HZ_19440);
         default: hz = 64'(`DPMC_HZ_8K);
      endcase
      return 32'((hz * 64'(GATE_CYCLES)) / 64'(`DPMC_CLK_HZ));
   endfunction

   function automatic logic is_hold(input dpmc_state_t s);
      return (s == HOLD_PRI) || (s == HOLD_SEC) || (s == AUTO_HOLD);
   endfunction

   // two-stage synchroniser for the reference, mode, choice, correction and fast lock pins
   always_ff @(posedge CLK) begin
      if (RESET) begin
         s1_r <= 7'h0;
         s2_r <= 7'h0;
      end else begin
         s1_r <= {FAST_LOCK_REQUEST, PHASE_CORRECTION_CONTROL, REFERENCE_CHOICE,
                  MODE_SELECT_HIGH_BIT, MODE_SELECT_LOW_BIT, SECONDARY_REFERENCE, PRIMARY_REFERENCE};
         s2_r <= s1_r;
      end
   end
   assign mode_w = s2_r[3:2];
   assign reference_choice_w = s2_r[4];
   assign pcc_w = s2_r[5];

   // shared gate: both monitors see the same window, counted on the master clock
   always_ff @(posedge CLK) begin
      gate_r <= (RESET || gate_w) ? 32'h0 : gate_r + 32'h1;
   end
   assign gate_w = (gate_r == 32'(GATE_CYCLES - 1));
   assign nom_w = nom_count(fs_r);
   assign tol_w = 32'((64'(nom_w) * 64'(`DPMC_OOR_PPM)) / 64'(`DPMC_PPM_DIV));
   assign pen_w = (fs_r == FS_8K) || (fs_r == FS_19440);

   // primary and secondary monitors run side by side
   dpmc_freq_mon #(.LOS_CYCLES(LOS_CYCLES)) u_mon_pri (
      .clk(CLK), .rst(RESET), .ref_s(s2_r[0]), .gate_tick(gate_w), .nom(nom_w),
      .tol(tol_w), .pulse_en(pen_w), .oor_r(pri_oor_w), .act_r(pri_act_w));
   dpmc_freq_mon #(.LOS_CYCLES(LOS_CYCLES)) u_mon_sec (
      .clk(CLK), .rst(RESET), .ref_s(s2_r[1]), .gate_tick(gate_w), .nom(nom_w),
      .tol(tol_w), .pulse_en(pen_w), .oor_r(sec_oor_w), .act_r(sec_act_w));
   assign PRIMARY_OUT_OF_RANGE = pri_oor_w;
   assign SECONDARY_OUT_OF_RANGE = sec_oor_w;

   // control state table; invalid and reserved requests leave the state alone
   always_comb begin
      state_nxt = state_r;
      tie_nxt = 1'b0;
      realign_nxt = 1'b0;
      case (mode_w)
         2'b00: begin
            if (state_r == AUTO_HOLD) begin
               if (reference_choice_w ? sec_act_w : pri_act_w) begin
                  state_nxt = reference_choice_w ? NORM_SEC : NORM_PRI;
                  tie_nxt = 1'b1;
               end
            end else if (!reference_choice_w && state_r != NORM_PRI) begin
               state_nxt = NORM_PRI;
               tie_nxt = (state_r == NORM_SEC) || (state_r == HOLD_SEC) || (state_r == HOLD_PRI && pcc_w);
               realign_nxt = (state_r == HOLD_PRI) && !pcc_w;
            end else if (reference_choice_w && state_r != NORM_SEC) begin
               state_nxt = NORM_SEC;
               tie_nxt = (state_r != FREERUN);
            end
         end
         2'b01: begin
            if (!reference_choice_w && state_r == NORM_PRI) begin
               state_nxt = HOLD_PRI;
            end else if (reference_choice_w && (state_r == NORM_PRI || state_r == NORM_SEC)) begin
               state_nxt = HOLD_SEC;
            end
         end
         2'b10: state_nxt = FREERUN;
         default: state_nxt = state_r;
      endcase
      // a dead active reference overrides the choice pin in normal states while the mode pins select normal (00)
      if ((state_r == NORM_PRI && !pri_act_w) || (state_r == NORM_SEC && !sec_act_w)) begin
         if (mode_w == 2'b00) begin
            state_nxt = AUTO_HOLD;
            tie_nxt = 1'b0;
            realign_nxt = 1'b0;
         end
      end
   end

   // state register and corrector status
   always_ff @(posedge CLK) begin
      if (RESET) begin
         state_r <= FREERUN;
         tie_r <= 1'b0;
      end else begin
         state_r <= state_nxt;
         if (state_nxt == FREERUN || realign_nxt) begin
            tie_r <= 1'b0;
         end else if (tie_nxt) begin
            tie_r <= 1'b1;
         end
      end
   end

   // state outputs, registered from the next state so they line up with it
   assign hold_w = is_hold(state_nxt);
   always_ff @(posedge CLK) begin
      if (RESET) begin
         HOLDOVER_IND <= 1'b0;
         STATE_CODE <= 3'h0;
         fast_r <= 1'b0;
      end else begin
         HOLDOVER_IND <= hold_w;
         STATE_CODE <= 3'(state_nxt);
         fast_r <= s2_r[6] && (state_nxt == NORM_PRI || state_nxt == NORM_SEC);
      end
   end
   assign FAST_LOCK = fast_r;
   assign TIE_ACTIVE = tie_r;

   // store the frequency every period while normal and locked, ping-ponging two slots
   assign store_ok_w = (state_r == NORM_PRI || state_r == NORM_SEC) && LOOP_LOCKED;
   always_ff @(posedge CLK) begin
      if (RESET) begin
         st_r <= 32'h0;
         wr_idx_r <= 1'b0;
         slot_r[0] <= 16'sh0;
         slot_r[1] <= 16'sh0;
      end else if (!store_ok_w) begin
         st_r <= 32'h0;
      end else if (st_r == 32'(STORE_CYCLES - 1)) begin
         st_r <= 32'h0;
         slot_r[wr_idx_r] <= clampf(LOOP_FREQ);
         wr_idx_r <= ~wr_idx_r;
      end else begin
         st_r <= st_r + 32'h1;
      end
   end

   // the older slot is the one 30 to 60 ms back; the newer may hold a disturbance
   always_ff @(posedge CLK) begin
      if (RESET) begin
         hold_r <= 16'sh0;
      end else if (hold_w && !is_hold(state_r)) begin
         hold_r <= slot_r[wr_idx_r];
      end
   end

   // frequency word: master clock only in freerun, stored value in holdover
   always_ff @(posedge CLK) begin
      if (RESET || state_nxt == FREERUN) begin
         FREQ_WORD <= 16'sh0;
      end else if (hold_w) begin
         FREQ_WORD <= (is_hold(state_r)) ? hold_r : slot_r[wr_idx_r];
      end else begin
         FREQ_WORD <= clampf(LOOP_FREQ);
      end
   end

   // realigning returns pull the output back onto the input, slowly
   dpmc_phase_lim u_lim (
      .clk(CLK), .rst(RESET), .load(realign_nxt && state_nxt != state_r),
      .target(PHASE_ERR_NS), .phase_r(PHASE_ADJ_NS));

   // APB slave: no wait states, answer registered in the setup cycle
   always_comb begin
      rd_hit_w = 1'b1;
      rd_w = 32'h0;
      case (PADDR)
         `DPMC_OFS_CTRL: rd_w = {30'h0, fs_r};
         `DPMC_OFS_STATUS: rd_w = {24'h0, fast_r, tie_r, HOLDOVER_IND, sec_oor_w, pri_oor_w, 3'(state_r)};
         `DPMC_OFS_HOLD: rd_w = {16'h0, hold_r};
         `DPMC_OFS_LIVE: rd_w = {16'h0, FREQ_WORD};
         default: rd_hit_w = 1'b0;
      endcase
   end
   always_ff @(posedge CLK) begin
      if (RESET) begin
         PREADY <= 1'b0;
         PSLVERR <= 1'b0;
         PRDATA <= 32'h0;
      end else begin
         PREADY <= PSEL && !PENABLE;
         PSLVERR <= PSEL && !PENABLE && !rd_hit_w;
         PRDATA <= (PSEL && !PENABLE && !PWRITE) ? rd_w : 32'h0;
      end
   end
   always_ff @(posedge CLK) begin
      if (RESET) begin
         fs_r <= `DPMC_CTRL_RST;
      end else if (PSEL && PENABLE && PREADY && PWRITE && PADDR == `DPMC_OFS_CTRL) begin
         fs_r <= PWDATA[`DPMC_CTRL_FS];
      end
   end

   default clocking cb @(posedge CLK); endclocking
   default disable iff (RESET);
   sequence s_auto_in;
      state_r == AUTO_HOLD ##0 HOLDOVER_IND;
   endsequence
   reserved_keep_a: assert property (mode_w == 2'b11 |=> $stable(state_r))
      else $error("reserved mode code changed state");
   freerun_go_a: assert property (mode_w == 2'b10 |=> state_r == FREERUN && FREQ_WORD == 16'sh0)
      else $error("freerun not entered");
   auto_hold_a: assert property (state_r == NORM_PRI && !pri_act_w && mode_w == 2'b00 |=> s_auto_in)
      else $error("automatic holdover not flagged");
   store_gate_a: assert property (!store_ok_w |=> $stable(slot_r[0]) && $stable(slot_r[1]))
      else $error("holdover store written while not locked");
   pri_select_a: assert property (mode_w == 2'b00 && !reference_choice_w && state_r == FREERUN |=> state_r == NORM_PRI)
      else $error("freerun did not go to normal primary");
   sec_select_a: assert property (mode_w == 2'b00 && reference_choice_w && state_r == NORM_PRI
      && sec_act_w && pri_act_w |=> state_r == NORM_SEC && tie_r)
      else $error("switch to secondary without corrector");
   hold_legal_a: assert property (mode_w == 2'b01 && reference_choice_w && state_r == HOLD_PRI |=> state_r == HOLD_PRI)
      else $error("invalid holdover transition taken");
   capt_range_a: assert property (FREQ_WORD <= `DPMC_CAPT_LIM && FREQ_WORD >= -`DPMC_CAPT_LIM)
      else $error("frequency word outside capture range");
   auto_exit_a: assert property (state_r == AUTO_HOLD && mode_w == 2'b00 && !reference_choice_w && pri_act_w
      |=> state_r == NORM_PRI && !HOLDOVER_IND && tie_r)
      else $error("automatic holdover not left");
endmodule
`default_nettype wire

//--- inc/dpmc_params.svh
// timing counts, limits, field positions and register offsets of the reference mode control
`ifndef DPMC_PARAMS_SVH
`define DPMC_PARAMS_SVH
`define DPMC_CLK_HZ 25000000
`define DPMC_PPM_DIV 1000000
`define DPMC_GATE_MS 1260
`define DPMC_GATE_CYC (`DPMC_CLK_HZ / 1000 * `DPMC_GATE_MS)
`define DPMC_OOR_PPM 17
`define DPMC_STORE_MS 30
`define DPMC_STORE_CYC (`DPMC_CLK_HZ / 1000 * `DPMC_STORE_MS)
`define DPMC_LOS_US 250
`define DPMC_LOS_CYC (`DPMC_CLK_HZ / 1000000 * `DPMC_LOS_US)
`define DPMC_FRAME_US 125
`define DPMC_FRAME_CYC (`DPMC_CLK_HZ / 1000000 * `DPMC_FRAME_US)
`define DPMC_STEP_NS 10'sd5
`define DPMC_PHASE_MAX_NS 10'sd200
`define DPMC_CAPT_LIM 16'sd23000
`define DPMC_HZ_8K 8000
`define DPMC_HZ_1544 1544000
`define DPMC_HZ_2048 2048000
`define DPMC_HZ_19440 19440000
`define DPMC_OFS_CTRL 8'h00
`define DPMC_OFS_STATUS 8'h04
`define DPMC_OFS_HOLD 8'h08
`define DPMC_OFS_LIVE 8'h0c
`define DPMC_CTRL_FS 1:0
`define DPMC_CTRL_RST 2'h0
`define DPMC_ST_OOR_P 3
`define DPMC_ST_OOR_S 4
`define DPMC_ST_HOLD 5
`define DPMC_ST_TIE 6
`define DPMC_ST_FAST 7
`endif

//--- inc/dpmc_pkg.sv
// types shared by the reference mode control
package dpmc_pkg;
   typedef enum logic [2:0] {FREERUN, NORM_PRI, NORM_SEC, HOLD_PRI, HOLD_SEC, AUTO_HOLD} dpmc_state_t;
   typedef enum logic [1:0] {FS_8K, FS_1544, FS_2048, FS_19440} dpmc_fs_t;
endpackage

//--- rtl/dpmc_freq_mon.sv
// one reference frequency monitor: edge count per gate, out-of-range flag, activity
`timescale 1ns/1ps
`default_nettype none
`include "dpmc_params.svh"
module dpmc_freq_mon #(
   parameter int unsigned LOS_CYCLES = `DPMC_LOS_CYC
) (
   input wire logic clk, // master clock
   input wire logic rst, // synchronous reset
   input wire logic ref_s, // reference, already synchronised
   input wire logic gate_tick, // end of measuring gate
   input wire logic [31:0] nom, // expected edges per gate
   input wire logic [31:0] tol, // allowed deviation in edges
   input wire logic pulse_en, // dead input gives a pulse, not a level
   output logic oor_r, // out-of-range flag
   output logic act_r // edges seen lately
);
   logic prev_r; // last sample for edge detect
   logic pulse_r; // a dead-input pulse is on
   logic [31:0] cnt_r; // edges this gate
   logic [31:0] los_r; // cycles since last edge
   logic edge_w; // rising edge
   logic [31:0] dev_w; // deviation from nominal
   assign edge_w = ref_s & ~prev_r;
   assign dev_w = (cnt_r > nom) ? cnt_r - nom : nom - cnt_r;

   // edge counter, restarted at each gate
   always_ff @(posedge clk) begin
      prev_r <= rst ? 1'b0 : ref_s;
      if (rst || gate_tick) begin
         cnt_r <= 32'h0;
      end else if (edge_w) begin
         cnt_r <= cnt_r + 32'h1;
      end
   end

   // flag refreshed once a gate; with pulse_en a dead input only blips for one master period
   always_ff @(posedge clk) begin
      if (rst) begin
         oor_r <= 1'b0;
         pulse_r <= 1'b0;
      end else if (gate_tick) begin
         pulse_r <= (cnt_r == 32'h0) && pulse_en;
         oor_r <= ((cnt_r == 32'h0) && pulse_en) || (dev_w > tol);
      end else if (pulse_r) begin
         pulse_r <= 1'b0;
         oor_r <= 1'b0;
      end
   end

   // loss-of-activity timer, feeds automatic holdover
   always_ff @(posedge clk) begin
      if (rst || edge_w) begin
         los_r <= 32'h0;
         act_r <= ~rst;
      end else if (los_r >= 32'(LOS_CYCLES)) begin
         act_r <= 1'b0;
      end else begin
         los_r <= los_r + 32'h1;
      end
   end

   default clocking cb @(posedge clk); endclocking
   default disable iff (rst);
   sequence s_blip;
      oor_r ##1 !oor_r;
   endsequence
   dead_pulse_a: assert property (gate_tick && cnt_r == 32'h0 && pulse_en |=> s_blip)
      else $error("dead reference did not give a one-cycle pulse");
   oor_refresh_a: assert property (!gate_tick && !pulse_r |=> $stable(oor_r))
      else $error("out-of-range flag changed between gates");
endmodule
`default_nettype wire

//--- rtl/dpmc_phase_lim.sv
// phase step and slope limiter for the output phase adjustment
`timescale 1ns/1ps
`default_nettype none
`include "dpmc_params.svh"
module dpmc_phase_lim (
   input wire logic clk, // master clock
   input wire logic rst, // synchronous reset
   input wire logic load, // new target after a realigning change
   input wire logic signed [9:0] target, // wanted phase, ns
   output logic signed [9:0] phase_r // applied phase, ns
);
   logic [11:0] frm_r; // frame timer
   logic signed [9:0] tgt_r; // clamped target
   logic signed [10:0] diff_w; // distance still to go
   logic tick_w; // frame boundary
   assign tick_w = (frm_r == 12'(`DPMC_FRAME_CYC - 1));
   assign diff_w = 11'(tgt_r) - 11'(phase_r);

   // frame timer
   always_ff @(posedge clk) begin
      frm_r <= (rst || tick_w) ? 12'h0 : frm_r + 12'h1;
   end

   // target never exceeds the total shift allowed
   always_ff @(posedge clk) begin
      if (rst) begin
         tgt_r <= 10'sh0;
      end else if (load) begin
         if (target > `DPMC_PHASE_MAX_NS) begin
            tgt_r <= `DPMC_PHASE_MAX_NS;
         end else if (target < -`DPMC_PHASE_MAX_NS) begin
            tgt_r <= -`DPMC_PHASE_MAX_NS;
         end else begin
            tgt_r <= target;
         end
      end
   end

   // at most one small step per frame, so the shift builds up slowly
   always_ff @(posedge clk) begin
      if (rst) begin
         phase_r <= 10'sh0;
      end else if (tick_w) begin
         if (diff_w > 11'(`DPMC_STEP_NS)) begin
            phase_r <= phase_r + `DPMC_STEP_NS;
         end else if (diff_w < -11'(`DPMC_STEP_NS)) begin
            phase_r <= phase_r - `DPMC_STEP_NS;
         end else begin
            phase_r <= tgt_r;
         end
      end
   end

   default clocking cb @(posedge clk); endclocking
   default disable iff (rst);
   slope_hold_a: assert property (!tick_w |=> $stable(phase_r))
      else $error("phase moved inside a frame");
   frame_step_a: assert property (tick_w |=> (phase_r - $past(phase_r) <= `DPMC_STEP_NS)
      && ($past(phase_r) - phase_r <= `DPMC_STEP_NS))
      else $error("phase step per frame too large");
   total_shift_a: assert property (phase_r <= `DPMC_PHASE_MAX_NS && phase_r >= -`DPMC_PHASE_MAX_NS)
      else $error("total phase shift above limit");
endmodule
`default_nettype wire

//--- verif/dpmc_ref_model.sv
// behavioural model of the two network references feeding the block
`timescale 1ns/1ps
`default_nettype none
module dpmc_ref_model #(
   parameter real HALF_NS = 244.140625 // half period of a 2.048 MHz reference
) (
   input wire logic en_p, // primary toggles while high
   input wire logic en_s, // secondary toggles while high
   input wire logic slow_s, // secondary at half rate, far off nominal
   output logic primary_reference, // primary reference
   output logic sec // secondary reference
);
   // a stopped reference holds its level: no transitions at all
   initial begin
      primary_reference = 1'b0;
      forever begin
         #(HALF_NS);
         if (en_p) primary_reference = ~primary_reference;
      end
   end
   // small offset keeps the secondary unrelated in phase to the primary
   initial begin
      sec = 1'b0;
      forever begin
         #(slow_s ? 2.0 * HALF_NS : HALF_NS + 0.013);
         if (en_s) sec = ~sec;
      end
   end
endmodule
`default_nettype wire

//--- verif/testbench.sv
// self-checking bench for the reference mode control
`timescale 1ns/1ps
`default_nettype none
module testbench;
   import dpmc_pkg::*;
   localparam int GATE = 3125; // whole number of 2.048 MHz periods, so the nominal count is exact
   localparam int LOS = 40; // above the reference period in cycles
   logic clk = 1'b0, rst = 1'b1, ms_hi = 1'b1, ms_lo = 1'b0, rchoice = 1'b0, pcc = 1'b0, fast_lock_request = 1'b0;
   logic locked = 1'b1, psel = 1'b0, penable = 1'b0, pwrite = 1'b0, en_p = 1'b1, en_s = 1'b1, slow_s = 1'b0;
   logic signed [15:0] loop_freq = 16'sh0064;
   logic signed [9:0] phase_err = 10'sh064;
   logic [7:0] paddr = 8'h00;
   logic [31:0] pwdata = 32'h0, prdata;
   logic pready, pslverr, pri_oor, sec_oor, hold_ind, tie, fast, primary_reference, sec;
   logic signed [15:0] freq_word;
   logic signed [9:0] phase_adj;
   logic [2:0] state_code;
   int bad_count = 0, n_checks = 0, cycles = 0;
   always #20 clk = ~clk;
   dpmc_ref_model u_dpmc_ref_model (.en_p(en_p), .en_s(en_s), .slow_s(slow_s), .primary_reference(primary_reference), .sec(sec));
   dpmc_top #(.GATE_CYCLES(GATE), .STORE_CYCLES(50), .LOS_CYCLES(LOS)) u_dpmc_top (.CLK(clk), .RESET(rst),
      .PRIMARY_REFERENCE(primary_reference), .SECONDARY_REFERENCE(sec), .MODE_SELECT_HIGH_BIT(ms_hi), .MODE_SELECT_LOW_BIT(ms_lo),
      .REFERENCE_CHOICE(rchoice), .PHASE_CORRECTION_CONTROL(pcc), .FAST_LOCK_REQUEST(fast_lock_request), .LOOP_FREQ(loop_freq),
      .LOOP_LOCKED(locked), .PHASE_ERR_NS(phase_err), .PSEL(psel), .PENABLE(penable), .PWRITE(pwrite),
      .PADDR(paddr), .PWDATA(pwdata), .PRDATA(prdata), .PREADY(pready), .PSLVERR(pslverr),
      .PRIMARY_OUT_OF_RANGE(pri_oor), .SECONDARY_OUT_OF_RANGE(sec_oor), .HOLDOVER_IND(hold_ind),
      .TIE_ACTIVE(tie), .FAST_LOCK(fast), .FREQ_WORD(freq_word), .PHASE_ADJ_NS(phase_adj), .STATE_CODE(state_code));
   // prints the counts and the verdict, then ends the run
   task automatic complete_run;
      $display("checks %0d mismatches %0d", n_checks, bad_count);
      if (bad_count == 0 && n_checks > 0) $display("Simulation passed");
      else $display("Simulation failed");
      $finish;
   endtask
   // compares a seen value with the expected one
   task automatic check(input logic [31:0] seen, input logic [31:0] exp, input string what);
      n_checks++;
      if (seen !== exp) begin
         bad_count++;
         $display("CHECK FAILED at %0t: %s seen %0h expected %0h", $time, what, seen, exp);
      end
   endtask
   task automatic wt(input int n);
      repeat (n) @(posedge clk);
   endtask
   // one APB transfer; request held until pready is sampled high
   task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] wd, output logic [31:0] rd,
      output logic err);
      @(posedge clk);
      psel <= 1'b1;
      pwrite <= wr;
      paddr <= a;
      pwdata <= wd;
      @(posedge clk);
      penable <= 1'b1;
      // a hung slave is ended by the bench timeout
      do begin
         @(posedge clk);
      end while (pready !== 1'b1);
      rd = prdata;
      err = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask
   // applies the control pins, then waits out the synchroniser
   task automatic pins(input logic [1:0] ms, input logic rc, input logic pc);
      @(posedge clk);
      {ms_hi, ms_lo} <= ms;
      rchoice <= rc;
      pcc <= pc;
      wt(5);
   endtask
   task automatic t_reset;
      logic [31:0] rd;
      logic err;
      check(state_code, 3'h0, "reset state");
      apb(1'b0, 8'h00, 32'h0, rd, err);
      check(rd, 32'h0, "control reset value");
      check(err, 1'b0, "control read error");
      apb(1'b0, 8'h40, 32'h0, rd, err);
      check(err, 1'b1, "unmapped address error");
   endtask
   // walks the freerun, normal, holdover-secondary and reserved rows of the control state table, invalid moves included
   task automatic t_modes;
      pins(2'b00, 1'b0, 1'b0);
      check({tie, state_code}, 4'h1, "freerun to normal primary");
      pins(2'b00, 1'b1, 1'b0);
      check({tie, state_code}, 4'ha, "to normal secondary via corrector");
      pins(2'b11, 1'b1, 1'b0); // reserved code
      check(state_code, 3'h2, "reserved code ignored");
      pins(2'b01, 1'b1, 1'b0);
      check({hold_ind, state_code}, 4'hc, "holdover secondary");
      pins(2'b01, 1'b0, 1'b0); // invalid holdover move
      check(state_code, 3'h4, "invalid move ignored");
      pins(2'b00, 1'b0, 1'b1);
      check({tie, state_code}, 4'h9, "holdover secondary back via corrector");
      pins(2'b10, 1'b1, 1'b1);
      check({hold_ind, freq_word, state_code}, 20'h0, "freerun from normal");
   endtask
   // holdover word, realignment through the limiter, clamp and fast lock
   task automatic t_hold;
      pins(2'b00, 1'b0, 1'b0);
      wt(60);
      loop_freq <= 16'sh0096; // newer slot differs from the older one
      wt(60);
      loop_freq <= 16'sh00c8;
      pins(2'b01, 1'b0, 1'b0);
      check({hold_ind, state_code}, 4'hb, "holdover primary");
      check(freq_word, 32'h64, "older stored word");
      pins(2'b01, 1'b1, 1'b0); // invalid holdover move
      check(state_code, 3'h3, "holdover primary kept");
      pins(2'b00, 1'b0, 1'b0);
      check({tie, state_code}, 4'h1, "return without corrector");
      wt(6300);
      check(phase_adj == 10'sd5 || phase_adj == 10'sd10, 1'b1, "phase slope");
      loop_freq <= 16'sd30000;
      fast_lock_request <= 1'b1;
      wt(5);
      check(freq_word, 32'd23000, "frequency clamp");
      check(fast, 1'b1, "fast lock");
   endtask
   // active reference stops, then resumes
   task automatic t_auto;
      en_p <= 1'b0;
      wt(LOS + 20);
      check({hold_ind, state_code}, 4'hd, "automatic holdover");
      en_p <= 1'b1;
      wt(LOS + 20);
      check({hold_ind, tie, state_code}, 5'h9, "leave automatic holdover");
   endtask
   task automatic t_monitors;
      logic [31:0] rd;
      logic err;
      int hi;
      pins(2'b10, 1'b0, 1'b0);
      apb(1'b1, 8'h00, 32'h2, rd, err);
      apb(1'b0, 8'h00, 32'h0, rd, err);
      check(rd, 32'h2, "frequency select read back");
      slow_s <= 1'b1;
      wt(2 * GATE + 20);
      check({pri_oor, sec_oor}, 2'b01, "secondary off nominal");
      apb(1'b1, 8'h00, 32'h0, rd, err);
      en_s <= 1'b0;
      wt(2 * GATE + 20);
      check(pri_oor, 1'b1, "primary off 8 kHz");
      hi = 0;
      repeat (2 * GATE) begin
         @(posedge clk);
         hi += (sec_oor === 1'b1);
      end
      check(hi, 2, "dead input pulses per gate");
   endtask
   always @(posedge clk) begin
      cycles <= cycles + 1;
      if (cycles == 40000) begin
         bad_count++;
         complete_run;
      end
   end
   initial begin
      wt(3);
      rst <= 1'b0;
      t_reset;
      t_modes;
      t_hold;
      t_auto;
      t_monitors;
      complete_run;
   end
endmodule
`default_nettype wire
